//--- logic/cpc_map.svh
// Register offsets, reset values and layout constants of the counter block
`ifndef CPC_MAP_SVH
`define CPC_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define CPC_OFF_CTRL 8'h00
`define CPC_OFF_INIT 8'h04
`define CPC_OFF_RELOAD 8'h08
`define CPC_OFF_COUNT 8'h0C
`define CPC_OFF_RESULT 8'h10
`define CPC_OFF_STATUS 8'h14

// ----------------------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------------------
`define CPC_CTRL_W 14
`define CPC_ST_ARMED 0
`define CPC_ST_DONE 1
`define CPC_ST_OVERRUN 2

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define CPC_CTRL_RST 14'h0000
`define CPC_WORD_RST 32'h0000_0000

`endif

//--- logic/cpc_pkg.sv
// Types shared by the counter block
package cpc_pkg;

	typedef enum logic [2:0] {
		CPC_PERIOD,
		CPC_POS_QUAD,
		CPC_POS_TWO,
		CPC_SEP_SINGLE,
		CPC_SEP_IMPL,
		CPC_SEP_SCLK
	} cpc_mode_type;

	typedef enum logic [1:0] {
		CPC_SINGLE_RATE_DECODING,
		CPC_DOUBLE_RATE_DECODING,
		CPC_QUADRUPLE_RATE_DECODING
	} cpc_rate_type;

	typedef enum logic [2:0] {
		CPC_ST_IDLE,
		CPC_ST_WAIT_START,
		CPC_ST_WAIT_GATE,
		CPC_ST_COUNT,
		CPC_ST_HOLD,
		CPC_ST_POS
	} cpc_state_type;

	// Control word, LSB first: arm, mode, rate, pos_buf, pols, samp_gate, zphase
	typedef struct packed {
		logic [1:0] zphase;
		logic samp_gate;
		logic samp_pol;
		logic aux_pol;
		logic gate_pol;
		logic src_pol;
		logic pos_buf;
		cpc_rate_type rate;
		cpc_mode_type mode;
		logic arm;
	} cpc_ctrl_type;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} cpc_bus_type;

	typedef struct packed {
		logic gate;
		logic aux;
		logic src;
		logic samp;
		logic enc_a;
		logic enc_b;
		logic enc_z;
	} cpc_pins_type;

endpackage

//--- logic/cpc_counter.sv
// Counter input logic: period, encoder position and edge separation
//
// Contract
// - Period between two active window edges, selectable polarity
// - Result is timebase edge count between them
// - No position counting before arm; single/buffered
// - Single rate: up on A rise, down A fall
// - Double rate: count both A edges, direction
// - Quadruple rate: count all A, B edges
// - Index high in chosen phase reloads count
// - Count step first, reload afterwards
// - Reload within one period, then count on
// - Two-pulse: up on A rise, down B
// - Buffered position samples cumulative count, no reset
// - Sample clock may be window input, polarity
// - First start edge begins counting, others ignored
// - Window edge stops, count goes to stream
// - Start and window polarities set independently
// - Single separation holds until result read
// - Implicit mode: next window edge restarts interval
// - Sample-clocked mode stores on sample edge
// - Missing interval between sample edges flags overrun
// - Buffered values stream out to host
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "cpc_map.svh"

module cpc_counter
	import cpc_pkg::*;
(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic nrst_i,
	// Register port
	input wire cpc_bus_type bus_i,
	output logic [31:0] rdata_o,
	// External signals, asynchronous
	input wire cpc_pins_type pins_i,
	// Stream to host memory
	output logic [31:0] strm_data_o,
	output logic strm_valid_o,
	input wire logic strm_ready_i
);

	// ------------------------------------------------------------------------
	// Input synchronisers and edge detection
	// ------------------------------------------------------------------------
	cpc_pins_type sync1_r;
	cpc_pins_type sync2_r;
	cpc_pins_type prev_r;

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sync1_r <= '0;
			sync2_r <= '0;
			prev_r <= '0;
		end else begin
			sync1_r <= pins_i;
			sync2_r <= sync1_r;
			prev_r <= sync2_r;
		end
	end

	cpc_ctrl_type ctrl_r;
	cpc_state_type state_r;
	logic [31:0] init_r;
	logic [31:0] reload_r;
	logic [31:0] pos_r;
	logic [31:0] cnt_r;
	logic [31:0] result_r;
	logic [31:0] pend_val_r;
	logic pend_r;
	logic done_r;
	logic overrun_r;

	logic tb_ev;
	logic gate_ev;
	logic aux_ev;
	logic samp_ev;
	logic samp_src;
	logic samp_prev;

	// Polarity bit low selects the rising edge
	assign tb_ev = ctrl_r.src_pol ? (prev_r.src & ~sync2_r.src) : (~prev_r.src & sync2_r.src);
	assign gate_ev = ctrl_r.gate_pol ? (prev_r.gate & ~sync2_r.gate) : (~prev_r.gate & sync2_r.gate);
	assign aux_ev = ctrl_r.aux_pol ? (prev_r.aux & ~sync2_r.aux) : (~prev_r.aux & sync2_r.aux);
	// Sample clock taken from the window input when selected
	assign samp_src = ctrl_r.samp_gate ? sync2_r.gate : sync2_r.samp;
	assign samp_prev = ctrl_r.samp_gate ? prev_r.gate : prev_r.samp;
	assign samp_ev = ctrl_r.samp_pol ? (samp_prev & ~samp_src) : (~samp_prev & samp_src);

	// ------------------------------------------------------------------------
	// Register port decode
	// ------------------------------------------------------------------------
	logic ctrl_wr;
	logic arm_go;
	logic disarm;
	logic res_rd;
	logic ovr_clr;

	assign ctrl_wr = bus_i.wr && (bus_i.addr == `CPC_OFF_CTRL);
	assign arm_go = ctrl_wr && bus_i.wdata[0] && (state_r == CPC_ST_IDLE);
	assign disarm = ctrl_wr && !bus_i.wdata[0];
	assign res_rd = bus_i.rd && (bus_i.addr == `CPC_OFF_RESULT);
	assign ovr_clr = bus_i.wr && (bus_i.addr == `CPC_OFF_STATUS) && bus_i.wdata[`CPC_ST_OVERRUN];

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ctrl_r <= cpc_ctrl_type'(`CPC_CTRL_RST);
			init_r <= `CPC_WORD_RST;
			reload_r <= `CPC_WORD_RST;
		end else if (bus_i.wr) begin
			if (bus_i.addr == `CPC_OFF_CTRL)
				ctrl_r <= cpc_ctrl_type'(bus_i.wdata[`CPC_CTRL_W-1:0]);
			if (bus_i.addr == `CPC_OFF_INIT)
				init_r <= bus_i.wdata;
			if (bus_i.addr == `CPC_OFF_RELOAD)
				reload_r <= bus_i.wdata;
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rdata_o <= `CPC_WORD_RST;
		end else if (!bus_i.rd) begin
			rdata_o <= `CPC_WORD_RST;
		end else begin
			case (bus_i.addr)
				`CPC_OFF_CTRL: rdata_o <= {18'h00000, ctrl_r};
				`CPC_OFF_INIT: rdata_o <= init_r;
				`CPC_OFF_RELOAD: rdata_o <= reload_r;
				`CPC_OFF_COUNT: rdata_o <= pos_r;
				`CPC_OFF_RESULT: rdata_o <= result_r;
				`CPC_OFF_STATUS: rdata_o <= {29'h00000000, overrun_r, done_r,
					state_r != CPC_ST_IDLE};
				default: rdata_o <= `CPC_WORD_RST;
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// Encoder decoding
	// ------------------------------------------------------------------------
	logic a_r;
	logic a_f;
	logic b_r;
	logic b_f;
	logic step_up;
	logic step_dn;
	logic z_hit;

	assign a_r = sync2_r.enc_a & ~prev_r.enc_a;
	assign a_f = ~sync2_r.enc_a & prev_r.enc_a;
	assign b_r = sync2_r.enc_b & ~prev_r.enc_b;
	assign b_f = ~sync2_r.enc_b & prev_r.enc_b;
	// Index phase code is {A, B}
	assign z_hit = sync2_r.enc_z && ({sync2_r.enc_a, sync2_r.enc_b} == ctrl_r.zphase);

	always_comb begin
		step_up = 1'b0;
		step_dn = 1'b0;
		if (ctrl_r.mode == CPC_POS_TWO) begin
			step_up = a_r;
			step_dn = b_r;
		end else begin
			case (ctrl_r.rate)
				CPC_SINGLE_RATE_DECODING: begin
					step_up = a_r & ~sync2_r.enc_b;
					step_dn = a_f & ~sync2_r.enc_b;
				end
				CPC_DOUBLE_RATE_DECODING: begin
					step_up = (a_r & ~sync2_r.enc_b) | (a_f & sync2_r.enc_b);
					step_dn = (a_r & sync2_r.enc_b) | (a_f & ~sync2_r.enc_b);
				end
				CPC_QUADRUPLE_RATE_DECODING: begin
					step_up = (a_r & ~sync2_r.enc_b) | (a_f & sync2_r.enc_b)
						| (b_r & sync2_r.enc_a) | (b_f & ~sync2_r.enc_a);
					step_dn = (a_r & sync2_r.enc_b) | (a_f & ~sync2_r.enc_b)
						| (b_r & ~sync2_r.enc_a) | (b_f & sync2_r.enc_a);
				end
				default: begin
					step_up = 1'b0;
					step_dn = 1'b0;
				end
			endcase
		end
	end

	// Reload waits for a cycle without a step, so a step entering the phase lands first
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pos_r <= `CPC_WORD_RST;
		end else if (arm_go) begin
			pos_r <= init_r;
		end else if (state_r == CPC_ST_POS) begin
			if (step_up != step_dn)
				pos_r <= step_up ? pos_r + 32'h0000_0001 : pos_r - 32'h0000_0001;
			else if (z_hit && ctrl_r.mode == CPC_POS_QUAD)
				pos_r <= reload_r;
		end
	end

	// ------------------------------------------------------------------------
	// Measurement sequencer
	// ------------------------------------------------------------------------
	logic sclk_mode;
	assign sclk_mode = ctrl_r.mode == CPC_SEP_SCLK;

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_r <= CPC_ST_IDLE;
			cnt_r <= `CPC_WORD_RST;
			result_r <= `CPC_WORD_RST;
			done_r <= 1'b0;
		end else if (disarm) begin
			state_r <= CPC_ST_IDLE;
		end else begin
			case (state_r)
				CPC_ST_IDLE: begin
					if (arm_go) begin
						done_r <= 1'b0;
						cnt_r <= `CPC_WORD_RST;
						case (cpc_mode_type'(bus_i.wdata[3:1]))
							CPC_PERIOD: state_r <= CPC_ST_WAIT_GATE;
							CPC_POS_QUAD, CPC_POS_TWO: state_r <= CPC_ST_POS;
							default: state_r <= CPC_ST_WAIT_START;
						endcase
					end
				end
				CPC_ST_WAIT_START: begin
					if (aux_ev) begin
						state_r <= CPC_ST_COUNT;
						cnt_r <= `CPC_WORD_RST;
					end
				end
				CPC_ST_WAIT_GATE: begin
					if (gate_ev) begin
						state_r <= CPC_ST_COUNT;
						cnt_r <= `CPC_WORD_RST;
					end
				end
				CPC_ST_COUNT: begin
					if (gate_ev) begin
						result_r <= cnt_r;
						done_r <= 1'b1;
						if (ctrl_r.mode == CPC_SEP_IMPL || sclk_mode)
							state_r <= CPC_ST_WAIT_GATE;
						else
							state_r <= CPC_ST_HOLD;
					end else if (tb_ev) begin
						cnt_r <= cnt_r + 32'h0000_0001;
					end
				end
				CPC_ST_HOLD: begin
					if (res_rd)
						state_r <= CPC_ST_IDLE;
				end
				CPC_ST_POS: state_r <= CPC_ST_POS;
				default: state_r <= CPC_ST_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// Sample-clocked hand-off and stream output
	// ------------------------------------------------------------------------
	logic fin;
	logic push;
	logic [31:0] push_data;
	logic miss;

	assign fin = (state_r == CPC_ST_COUNT) && gate_ev && !disarm;

	always_comb begin
		push = 1'b0;
		push_data = cnt_r;
		miss = 1'b0;
		if (state_r == CPC_ST_POS && ctrl_r.pos_buf && samp_ev) begin
			push = 1'b1;
			push_data = pos_r;
		end else if (sclk_mode && state_r != CPC_ST_IDLE && samp_ev) begin
			push = fin || pend_r;
			push_data = fin ? cnt_r : pend_val_r;
			miss = !(fin || pend_r);
		end else if (fin && !sclk_mode) begin
			push = 1'b1;
		end
	end

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pend_r <= 1'b0;
			pend_val_r <= `CPC_WORD_RST;
		end else if (arm_go) begin
			pend_r <= 1'b0;
		end else if (sclk_mode && samp_ev) begin
			pend_r <= 1'b0;
		end else if (fin) begin
			pend_r <= 1'b1;
			pend_val_r <= cnt_r;
		end
	end

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			strm_valid_o <= 1'b0;
			strm_data_o <= `CPC_WORD_RST;
		end else if (push && (!strm_valid_o || strm_ready_i)) begin
			strm_valid_o <= 1'b1;
			strm_data_o <= push_data;
		end else if (strm_ready_i) begin
			strm_valid_o <= 1'b0;
		end
	end

	// Set wins over the software clear
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i)
			overrun_r <= 1'b0;
		else if (miss || (push && strm_valid_o && !strm_ready_i))
			overrun_r <= 1'b1;
		else if (arm_go || ovr_clr)
			overrun_r <= 1'b0;
	end

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!nrst_i);

	sequence s_period_open;
		state_r == CPC_ST_WAIT_GATE && ctrl_r.mode == CPC_PERIOD && gate_ev && !disarm;
	endsequence

	sequence s_counting;
		state_r == CPC_ST_COUNT && cnt_r == 32'h0000_0000;
	endsequence

	property p_period_open;
		s_period_open |=> s_counting;
	endproperty
	a_period_open: assert property (p_period_open) else $error("period did not open");

	property p_tb_count;
		state_r == CPC_ST_COUNT && tb_ev && !gate_ev && !disarm |=> cnt_r == $past(cnt_r) + 1;
	endproperty
	a_tb_count: assert property (p_tb_count) else $error("timebase edge not counted");

	property p_pos_idle;
		state_r != CPC_ST_POS && !arm_go |=> $stable(pos_r);
	endproperty
	a_pos_idle: assert property (p_pos_idle) else $error("position moved while not armed");

	property p_x1_up;
		state_r == CPC_ST_POS && ctrl_r.mode == CPC_POS_QUAD && !disarm
			&& ctrl_r.rate == CPC_SINGLE_RATE_DECODING && a_r && !sync2_r.enc_b
			|=> pos_r == $past(pos_r) + 1;
	endproperty
	a_x1_up: assert property (p_x1_up) else $error("single rate increment missed");

	property p_two_dn;
		state_r == CPC_ST_POS && ctrl_r.mode == CPC_POS_TWO && b_r && !a_r && !disarm
			|=> pos_r == $past(pos_r) - 1;
	endproperty
	a_two_dn: assert property (p_two_dn) else $error("two-pulse decrement missed");

	sequence s_reload_due;
		state_r == CPC_ST_POS && ctrl_r.mode == CPC_POS_QUAD && z_hit && step_up == step_dn
			&& !disarm;
	endsequence

	property p_reload;
		s_reload_due |=> pos_r == reload_r;
	endproperty
	a_reload: assert property (p_reload) else $error("index reload missing");

	property p_start_once;
		state_r == CPC_ST_WAIT_START && aux_ev && !disarm |=> state_r == CPC_ST_COUNT
			##1 (state_r == CPC_ST_COUNT || state_r == CPC_ST_HOLD
			|| state_r == CPC_ST_WAIT_GATE || state_r == CPC_ST_IDLE);
	endproperty
	a_start_once: assert property (p_start_once) else $error("start edge not taken");

	property p_hold;
		state_r == CPC_ST_HOLD && !res_rd && !disarm |=> state_r == CPC_ST_HOLD;
	endproperty
	a_hold: assert property (p_hold) else $error("single result left before read");

	property p_miss;
		miss |=> overrun_r;
	endproperty
	a_miss: assert property (p_miss) else $error("overrun not flagged");

	property p_pos_sample;
		state_r == CPC_ST_POS && ctrl_r.pos_buf && samp_ev && !strm_valid_o
			|=> strm_valid_o && strm_data_o == $past(pos_r);
	endproperty
	a_pos_sample: assert property (p_pos_sample) else $error("position sample lost");

endmodule // cpc_counter
`default_nettype wire

//--- tb/cpc_far_end.sv
// Model of the encoder tracks, timebase and trigger lines outside the counter
`timescale 1ns/1ns
`default_nettype none

module cpc_far_end
	import cpc_pkg::*;
(
	// Clock
	input wire logic mclk_i,
	// Lines into the block
	output var cpc_pins_type pins_o
);
	initial pins_o = '0;

	// Each level holds five cycles so the two-stage synchroniser always sees it
	task automatic drive(input logic [6:0] m, input logic v);
		@(posedge mclk_i);
		pins_o <= v ? cpc_pins_type'(pins_o | m) : cpc_pins_type'(pins_o & ~m);
		repeat (4) @(posedge mclk_i);
	endtask

	task automatic pulse(input logic [6:0] m, input int n);
		repeat (n) begin
			drive(m, 1'b1);
			drive(m, 1'b0);
		end
	endtask

	// Full quadrature cycles, track A leading when fwd is set
	task automatic quad(input logic fwd, input int n);
		logic [6:0] p;
		logic [6:0] q;
		p = fwd ? 7'h04 : 7'h02;
		q = fwd ? 7'h02 : 7'h04;
		repeat (n) begin
			drive(p, 1'b1);
			drive(q, 1'b1);
			drive(p, 1'b0);
			drive(q, 1'b0);
		end
	endtask
endmodule // cpc_far_end

`default_nettype wire

//--- tb/cpc_counter_tb.sv
// Self-checking bench for the counter block
`timescale 1ns/1ns
`default_nettype none
`include "cpc_map.svh"

module cpc_counter_tb
	import cpc_pkg::*;
;
	localparam logic [6:0] m_gate = 7'h40;
	localparam logic [6:0] m_aux = 7'h20;
	localparam logic [6:0] m_src = 7'h10;
	localparam logic [6:0] m_samp = 7'h08;
	localparam logic [6:0] m_enc_a = 7'h04;
	localparam logic [6:0] m_enc_b = 7'h02;
	localparam logic [6:0] m_enc_z = 7'h01;

	logic mclk_i;
	logic nrst_i;
	cpc_bus_type bus;
	logic [31:0] rdata;
	cpc_pins_type pins;
	logic [31:0] strm_data;
	logic strm_valid;
	logic strm_ready;
	int n_fail;
	int n_compared;
	cpc_ctrl_type c;
	logic [31:0] d;

	cpc_counter cpc_counter_i (.mclk_i(mclk_i), .nrst_i(nrst_i), .bus_i(bus), .rdata_o(rdata),
		.pins_i(pins), .strm_data_o(strm_data), .strm_valid_o(strm_valid),
		.strm_ready_i(strm_ready));
	cpc_far_end cpc_far_end_i (.mclk_i(mclk_i), .pins_o(pins));

	initial begin
		mclk_i = 1'b0;
		forever #20 mclk_i = ~mclk_i;
	end

	// ------------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		$display("Compared %0d, mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge mclk_i);
		bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge mclk_i);
		bus.wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge mclk_i);
		bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge mclk_i);
		bus.rd <= 1'b0;
		// Read data stand only in this cycle; take them mid-cycle, clear of the edges
		@(negedge mclk_i);
		v = rdata;
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] v;
		rd(a, v);
		check(v, exp);
	endtask

	// Disarm, load the start value and arm; any stale stream word is drained
	task automatic arm(input cpc_ctrl_type cc, input logic [31:0] init);
		strm_ready <= 1'b1;
		wr(`CPC_OFF_CTRL, 32'h0);
		wr(`CPC_OFF_INIT, init);
		cc.arm = 1'b1;
		wr(`CPC_OFF_CTRL, 32'(cc));
		strm_ready <= 1'b0;
	endtask

	// The host stalls until the word is seen, then accepts it
	task automatic take(input logic [31:0] exp);
		for (int i = 0; i < 100 && strm_valid !== 1'b1; i++) begin
			@(posedge mclk_i);
		end
		check({31'h0, strm_valid}, 32'h1);
		check(strm_data, exp);
		strm_ready <= 1'b1;
		@(posedge mclk_i);
		strm_ready <= 1'b0;
	endtask

	// ------------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------------
	task automatic t_regs();
		for (int i = 0; i < 6; i++) begin
			rc(8'(4 * i), 32'h0);
		end
		wr(`CPC_OFF_INIT, 32'hA5A5_1234);
		wr(8'h40, 32'hFFFF_FFFF);
		rc(`CPC_OFF_INIT, 32'hA5A5_1234);
		rc(8'h40, 32'h0);
	endtask

	task automatic t_period();
		c = '0;
		c.mode = CPC_PERIOD;
		arm(c, 32'h0);
		cpc_far_end_i.pulse(m_gate, 1);
		cpc_far_end_i.pulse(m_src, 5);
		cpc_far_end_i.pulse(m_gate, 1);
		take(32'h5);
		rc(`CPC_OFF_RESULT, 32'h5);
	endtask

	task automatic t_quad();
		for (int r = 0; r < 3; r++) begin
			c = '0;
			c.mode = CPC_POS_QUAD;
			c.rate = cpc_rate_type'(r);
			arm(c, 32'h64);
			cpc_far_end_i.quad(1'b1, 2);
			rc(`CPC_OFF_COUNT, 32'h64 + (32'h2 << r));
			cpc_far_end_i.quad(1'b0, 1);
			rc(`CPC_OFF_COUNT, 32'h64 + (32'h1 << r));
		end
		wr(`CPC_OFF_CTRL, 32'h0);
		rd(`CPC_OFF_COUNT, d);
		cpc_far_end_i.quad(1'b1, 1);
		rc(`CPC_OFF_COUNT, d);
	endtask

	// Index rises in a non-reload phase; entering the reload phase steps then reloads
	task automatic t_index();
		c = '0;
		c.mode = CPC_POS_QUAD;
		c.rate = CPC_QUADRUPLE_RATE_DECODING;
		wr(`CPC_OFF_RELOAD, 32'h1F4);
		arm(c, 32'h0);
		cpc_far_end_i.drive(m_enc_a, 1'b1);
		cpc_far_end_i.drive(m_enc_b, 1'b1);
		cpc_far_end_i.drive(m_enc_a, 1'b0);
		cpc_far_end_i.drive(m_enc_z, 1'b1);
		cpc_far_end_i.drive(m_enc_b, 1'b0);
		rc(`CPC_OFF_COUNT, 32'h1F4);
		cpc_far_end_i.drive(m_enc_z, 1'b0);
		cpc_far_end_i.quad(1'b1, 1);
		rc(`CPC_OFF_COUNT, 32'h1F8);
	endtask

	task automatic t_two();
		c = '0;
		c.mode = CPC_POS_TWO;
		arm(c, 32'hA);
		cpc_far_end_i.pulse(m_enc_a, 3);
		cpc_far_end_i.pulse(m_enc_b, 1);
		rc(`CPC_OFF_COUNT, 32'hC);
	endtask

	task automatic t_posbuf();
		c = '0;
		c.mode = CPC_POS_QUAD;
		c.pos_buf = 1'b1;
		arm(c, 32'h32);
		cpc_far_end_i.quad(1'b1, 2);
		cpc_far_end_i.pulse(m_samp, 1);
		take(32'h34);
		cpc_far_end_i.quad(1'b1, 1);
		cpc_far_end_i.pulse(m_samp, 1);
		take(32'h35);
		c.samp_gate = 1'b1;
		c.samp_pol = 1'b1;
		arm(c, 32'h0);
		cpc_far_end_i.quad(1'b1, 1);
		cpc_far_end_i.drive(m_gate, 1'b1);
		check({31'h0, strm_valid}, 32'h0);
		cpc_far_end_i.drive(m_gate, 1'b0);
		take(32'h1);
	endtask

	// Start on falling start-edge, stop on rising window edge
	task automatic t_sep_single();
		c = '0;
		c.mode = CPC_SEP_SINGLE;
		c.aux_pol = 1'b1;
		arm(c, 32'h0);
		cpc_far_end_i.drive(m_aux, 1'b1);
		cpc_far_end_i.pulse(m_src, 2);
		cpc_far_end_i.drive(m_aux, 1'b0);
		cpc_far_end_i.pulse(m_src, 1);
		cpc_far_end_i.pulse(m_aux, 1);
		cpc_far_end_i.pulse(m_src, 2);
		cpc_far_end_i.pulse(m_gate, 1);
		take(32'h3);
		cpc_far_end_i.pulse(m_aux, 1);
		cpc_far_end_i.pulse(m_src, 2);
		cpc_far_end_i.pulse(m_gate, 1);
		check({31'h0, strm_valid}, 32'h0);
		rc(`CPC_OFF_RESULT, 32'h3);
	endtask

	// Falling window and timebase edges; intervals repeat without re-arming
	task automatic t_sep_impl();
		c = '0;
		c.mode = CPC_SEP_IMPL;
		c.gate_pol = 1'b1;
		c.src_pol = 1'b1;
		arm(c, 32'h0);
		cpc_far_end_i.pulse(m_aux, 1);
		cpc_far_end_i.pulse(m_src, 2);
		cpc_far_end_i.pulse(m_gate, 1);
		take(32'h2);
		cpc_far_end_i.pulse(m_src, 3);
		cpc_far_end_i.pulse(m_gate, 1);
		cpc_far_end_i.pulse(m_src, 1);
		cpc_far_end_i.pulse(m_aux, 1);
		cpc_far_end_i.pulse(m_src, 3);
		cpc_far_end_i.pulse(m_gate, 1);
		take(32'h4);
		rc(`CPC_OFF_RESULT, 32'h4);
	endtask

	task automatic t_sep_sclk();
		c = '0;
		c.mode = CPC_SEP_SCLK;
		arm(c, 32'h0);
		cpc_far_end_i.pulse(m_aux, 1);
		cpc_far_end_i.pulse(m_src, 2);
		cpc_far_end_i.pulse(m_gate, 1);
		check({31'h0, strm_valid}, 32'h0);
		cpc_far_end_i.pulse(m_samp, 1);
		take(32'h2);
		cpc_far_end_i.pulse(m_samp, 1);
		rd(`CPC_OFF_STATUS, d);
		check({31'h0, d[`CPC_ST_OVERRUN]}, 32'h1);
		arm(c, 32'h0);
		rd(`CPC_OFF_STATUS, d);
		check(d & 32'h5, 32'h1);
	endtask

	// ------------------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------------------
	initial begin
		n_fail = 0;
		n_compared = 0;
		nrst_i = 1'b0;
		bus = '0;
		strm_ready = 1'b0;
		c = '0;
		d = 32'h0;
		repeat (20) @(posedge mclk_i);
		nrst_i <= 1'b1;
		t_regs();
		t_period();
		t_quad();
		t_index();
		t_two();
		t_posbuf();
		t_sep_single();
		t_sep_impl();
		t_sep_sclk();
		complete_run();
	end

	// The scenarios need about a thousand cycles; this span is some thirty times that
	initial begin
		repeat (30000) @(posedge mclk_i);
		n_fail++;
		complete_run();
	end
endmodule // cpc_counter_tb

`default_nettype wire
